// [rtl/pcb_regs.vh]
// Register offsets, field positions, reset values and counts for PHY config.
`ifndef PCB_REGS_VH
`define PCB_REGS_VH
`define PCB_IDX_PHY_CONFIG_TWO 8'h14
`define PCB_IDX_RXERR 8'h15
`define PCB_IDX_BIST 8'h16
`define PCB_IDX_STAT 8'h17
`define PCB_PHY_CONFIG_TWO_RST 16'h2947
`define PCB_PHY_CONFIG_TWO_WMASK 16'h2f40
`define PCB_BIST_WMASK 16'hf0ff
`define PCB_BIT_IRQPOL 13
`define PCB_BIT_DSEN 9
`define PCB_BIT_DSENERGY 8
`define PCB_BIT_DSTEN 6
`define PCB_BIT_WRAP 15
`define PCB_BIT_RAND 14
`define PCB_BIT_SHORT 13
`define PCB_BIT_GEN 12
`define PCB_BIT_FWDRX 7
`define PCB_BIT_FWDTX 6
`define PCB_LEN_SHORT 11'h040
`define PCB_LEN_LONG 11'h5ee
`define PCB_SPD_1G 2'h2
`define PCB_SPD_100 2'h1
`define PCB_SPD_10 2'h0
`endif

// [rtl/pcb_frame_gen.v]
// Self-test frame generator: byte counter, PRBS source and busy flag.
`timescale 1ns/1ps
`default_nettype none
`include "pcb_regs.vh"
module pcb_frame_gen (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Control
  input wire enable,
  input wire randomPayload,
  input wire shortFrame,
  input wire wrapMode,
  // Stream out
  output reg byteValid,
  output reg [7:0] byteData,
  output reg frameEnd,
  output reg wrapPulse,
  output reg busy
);
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN = 2'h1;
  localparam ST_DONE = 2'h2;
  reg [1:0] state_q;
  reg [10:0] count_q;
  reg [14:0] lfsr_q;
  wire [10:0] lastByte;
  wire lfsrFb;
  assign lastByte = (shortFrame ? `PCB_LEN_SHORT : `PCB_LEN_LONG) - 11'h001;
  assign lfsrFb = lfsr_q[14] ^ lfsr_q[13];
  always @(posedge mclk)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      count_q <= 11'h000;
      lfsr_q <= 15'h7fff;
      byteValid <= 1'b0;
      byteData <= 8'h00;
      frameEnd <= 1'b0;
      wrapPulse <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      frameEnd <= 1'b0;
      wrapPulse <= 1'b0;
      byteValid <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          count_q <= 11'h000;
          busy <= enable;
          if (enable)
            state_q <= ST_RUN;
        end
        ST_RUN:
        begin
          if (!enable)
          begin
            state_q <= ST_IDLE;
            busy <= 1'b0;
          end
          else
          begin
            byteValid <= 1'b1;
            if (randomPayload)
            begin
              lfsr_q <= {lfsr_q[13:0], lfsrFb};
              byteData <= lfsr_q[7:0];
            end
            else
              byteData <= 8'h55;
            if (count_q == lastByte)
            begin
              frameEnd <= 1'b1;
              count_q <= 11'h000;
              // A wrap pulse needs continuous mode; only a constant payload stops after the frame.
              wrapPulse <= wrapMode;
              if (!randomPayload)
              begin
                state_q <= ST_DONE;
                busy <= 1'b0;
              end
            end
            else
              count_q <= count_q + 11'h001;
          end
        end
        default:
        begin
          // Single frame sent; wait for software to drop the enable.
          busy <= 1'b0;
          if (!enable)
            state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// [rtl/pcb_config_regs.v]
// AHB-Lite register bank: config 2, receive error tally and self-test control.
// Contract
// - Interrupt pin active low when polarity bit is 1, else high; resets 1.
// - Try count code 11=8, 10=4, 01=2, 00=1 gigabit failures; resets 10.
// - Downshift enable allows speed optimisation after the chosen failures.
// - Energy mode also downshifts when pairs C and D show no energy.
// - Ten-enable falls back to 10 Mbit after gigabit and 100 Mbit fail.
// - Reserved bits ignore writes and read zero or their fixed default.
// - Sixteen-bit receive error tally saturates at 0xffff.
// - Any write to the error tally register clears it.
// - Continuous mode wraps self-test counters with a pulse; software sets.
// - Random payload: continuous PRBS frames; checker stays on when idle.
// - Constant payload: one frame only, PRBS generation and checking off.
// - Frames are 64 bytes with short select, 1518 bytes otherwise.
// - Reverse loop forwards received frames to MAC only when bit set.
// - MII loop also transmits looped data to the line when bit set.
// - Loop select one-hot: 1000 rev, 0100 ext, 0010 analog, 0001 digital.
// - Coding loop: 11 after encoder, 10 mid, 01 before scrambler; gig x1.
// - Downshift event latches pending bit cleared by reading it.
`timescale 1ns/1ps
`default_nettype none
`include "pcb_regs.vh"
module pcb_config_regs (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Link status from the PHY core
  input wire gigFailPulse,
  input wire fastFailPulse,
  input wire linkUpPulse,
  input wire pairsCdEnergy,
  input wire rxErrorPulse,
  input wire downshiftIrqEnable,
  input wire otherIrqPending,
  // Link control
  output reg [1:0] speedSelect,
  output reg downshiftEventPulse,
  output reg irqPin,
  // Self-test stream and checker
  output reg stByteValid,
  output reg [7:0] stByteData,
  output reg stFrameEnd,
  output reg stWrapPulse,
  output reg prbsCheckEnable,
  // Loopback steering
  output reg [3:0] loopSelectOneHot,
  output reg reverseLoopOn,
  output reg externalLoopOn,
  output reg analogLoopOn,
  output reg digitalLoopOn,
  output reg forwardRxToMac,
  output reg forwardTxToLine,
  output reg [2:0] codingLoopPoint
);
  reg [15:0] phy_config_two_q;
  reg [15:0] rxFaultTally_q;
  reg [15:0] bist_q;
  reg downshiftEventPending_q;
  reg pendingSeen_q;
  reg [3:0] gigFails_q;
  reg fastFailed_q;
  reg [31:0] addr_q;
  reg wr_q;
  reg rd_q;
  reg [15:0] rdData;
  wire take;
  wire [3:0] tryLimit;
  wire reachedLimit;
  wire energyShift;
  wire genByteValid;
  wire [7:0] genByteData;
  wire genFrameEnd;
  wire genWrap;
  wire frameGeneratorBusy;
  wire [1:0] downshiftTryCount;
  wire downshiftEnable;
  wire downshiftEnergyMode;
  wire downshiftToTenEnable;
  wire [1:0] codingLoopSelect;
  wire randomPayloadSelect;
  wire frameGeneratorEnable;
  wire rxWrite;
  wire statRead;
  wire shiftEvent;

  // Decodes the two-bit try count into a number of gigabit failures.
  function [3:0] tryDecode;
    input [1:0] code;
    begin
      case (code)
        2'h3: tryDecode = 4'h8;
        2'h2: tryDecode = 4'h4;
        2'h1: tryDecode = 4'h2;
        default: tryDecode = 4'h1;
      endcase
    end
  endfunction

  // Flags a decoded register index on a word-aligned byte address.
  function isReg;
    input [31:0] addr;
    input [7:0] idx;
    begin
      isReg = (addr[31:10] == 22'h000000) && (addr[9:2] == idx) &&
        (addr[1:0] == 2'h0);
    end
  endfunction

  assign downshiftTryCount = phy_config_two_q[11:10];
  assign downshiftEnable = phy_config_two_q[`PCB_BIT_DSEN];
  assign downshiftEnergyMode = phy_config_two_q[`PCB_BIT_DSENERGY];
  assign downshiftToTenEnable = phy_config_two_q[`PCB_BIT_DSTEN];
  assign codingLoopSelect = bist_q[1:0];
  assign randomPayloadSelect = bist_q[`PCB_BIT_RAND];
  assign frameGeneratorEnable = bist_q[`PCB_BIT_GEN];

  assign take = hsel && hready && htrans[1];
  assign tryLimit = tryDecode(downshiftTryCount);
  assign reachedLimit = gigFailPulse && (gigFails_q + 4'h1 >= tryLimit);
  assign energyShift = downshiftEnergyMode && !pairsCdEnergy &&
    gigFailPulse;
  assign rxWrite = wr_q && isReg(addr_q, `PCB_IDX_RXERR);
  assign statRead = rd_q && isReg(addr_q, `PCB_IDX_STAT);
  assign shiftEvent = downshiftEnable && speedSelect == `PCB_SPD_1G &&
    (reachedLimit || energyShift);

  pcb_frame_gen u_gen (
    .mclk(mclk),
    .rst(rst),
    .enable(frameGeneratorEnable),
    .randomPayload(randomPayloadSelect),
    .shortFrame(bist_q[`PCB_BIT_SHORT]),
    .wrapMode(bist_q[`PCB_BIT_WRAP]),
    .byteValid(genByteValid),
    .byteData(genByteData),
    .frameEnd(genFrameEnd),
    .wrapPulse(genWrap),
    .busy(frameGeneratorBusy)
  );

  // Bus pipeline: address phase captured, data phase served without wait.
  always @(posedge mclk)
  begin
    if (rst)
    begin
      addr_q <= 32'h00000000;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready)
      begin
        addr_q <= haddr;
        wr_q <= take && hwrite;
        rd_q <= take && !hwrite;
      end
    end
  end

  // Read mux uses the address phase so data is ready for the data phase.
  always @*
  begin
    rdData = 16'h0000;
    if (isReg(haddr, `PCB_IDX_PHY_CONFIG_TWO))
      rdData = phy_config_two_q;
    else if (isReg(haddr, `PCB_IDX_RXERR))
      rdData = rxFaultTally_q;
    else if (isReg(haddr, `PCB_IDX_BIST))
      rdData = bist_q;
    else if (isReg(haddr, `PCB_IDX_STAT))
      rdData = {6'h00, frameGeneratorBusy, 3'h0, downshiftEventPending_q,
        5'h00};
  end

  always @(posedge mclk)
  begin
    if (rst)
      hrdata <= 32'h00000000;
    else if (take && !hwrite)
      hrdata <= {16'h0000, rdData};
  end

  // Register writes; reserved bits keep their fixed values.
  always @(posedge mclk)
  begin
    if (rst)
    begin
      phy_config_two_q <= `PCB_PHY_CONFIG_TWO_RST;
      bist_q <= 16'h0000;
    end
    else if (wr_q)
    begin
      if (isReg(addr_q, `PCB_IDX_PHY_CONFIG_TWO))
        phy_config_two_q <= (hwdata[15:0] & `PCB_PHY_CONFIG_TWO_WMASK) |
          (`PCB_PHY_CONFIG_TWO_RST & ~`PCB_PHY_CONFIG_TWO_WMASK);
      else if (isReg(addr_q, `PCB_IDX_BIST))
        bist_q <= hwdata[15:0] & `PCB_BIST_WMASK;
    end
  end

  // Error tally: a write clears, otherwise counts and holds at full scale.
  always @(posedge mclk)
  begin
    if (rst)
      rxFaultTally_q <= 16'h0000;
    else if (rxWrite)
      rxFaultTally_q <= 16'h0000;
    else if (rxErrorPulse && rxFaultTally_q != 16'hffff)
      rxFaultTally_q <= rxFaultTally_q + 16'h0001;
  end

  // Downshift policy: counts gigabit failures, then 100 Mbit, then 10 Mbit.
  always @(posedge mclk)
  begin
    if (rst)
    begin
      gigFails_q <= 4'h0;
      fastFailed_q <= 1'b0;
      speedSelect <= `PCB_SPD_1G;
      downshiftEventPulse <= 1'b0;
    end
    else
    begin
      downshiftEventPulse <= 1'b0;
      if (linkUpPulse)
        gigFails_q <= 4'h0;
      else if (shiftEvent)
      begin
        gigFails_q <= 4'h0;
        speedSelect <= `PCB_SPD_100;
        downshiftEventPulse <= 1'b1;
      end
      else if (gigFailPulse && speedSelect == `PCB_SPD_1G)
        gigFails_q <= gigFails_q + 4'h1;
      // The ten fallback only follows a failed gigabit downshift.
      if (fastFailPulse && speedSelect == `PCB_SPD_100)
      begin
        fastFailed_q <= 1'b1;
        if (downshiftToTenEnable)
        begin
          speedSelect <= `PCB_SPD_10;
          downshiftEventPulse <= 1'b1;
        end
      end
      if (!downshiftEnable)
        speedSelect <= `PCB_SPD_1G;
    end
  end

  // Pending bit: a new event beats the read that would clear it, and a read
  // only clears what it reported, so an event between its phases survives.
  always @(posedge mclk)
  begin
    if (rst)
    begin
      downshiftEventPending_q <= 1'b0;
      pendingSeen_q <= 1'b0;
    end
    else
    begin
      if (take && !hwrite && isReg(haddr, `PCB_IDX_STAT))
        pendingSeen_q <= downshiftEventPending_q;
      if (downshiftEventPulse)
        downshiftEventPending_q <= 1'b1;
      else if (statRead && pendingSeen_q)
        downshiftEventPending_q <= 1'b0;
    end
  end

  // Pin drive and loopback decode, all registered.
  always @(posedge mclk)
  begin
    if (rst)
    begin
      // Idle level for the reset polarity, so reset raises no interrupt.
      irqPin <= 1'b1;
      stByteValid <= 1'b0;
      stByteData <= 8'h00;
      stFrameEnd <= 1'b0;
      stWrapPulse <= 1'b0;
      prbsCheckEnable <= 1'b0;
      loopSelectOneHot <= 4'h0;
      reverseLoopOn <= 1'b0;
      externalLoopOn <= 1'b0;
      analogLoopOn <= 1'b0;
      digitalLoopOn <= 1'b0;
      forwardRxToMac <= 1'b0;
      forwardTxToLine <= 1'b0;
      codingLoopPoint <= 3'h0;
    end
    else
    begin
      irqPin <= ((downshiftEventPending_q && downshiftIrqEnable) ||
        otherIrqPending) ^ phy_config_two_q[`PCB_BIT_IRQPOL];
      stByteValid <= genByteValid;
      stByteData <= genByteData;
      stFrameEnd <= genFrameEnd;
      stWrapPulse <= genWrap;
      prbsCheckEnable <= randomPayloadSelect;
      loopSelectOneHot <= bist_q[5:2];
      reverseLoopOn <= bist_q[5:2] == 4'h8;
      externalLoopOn <= bist_q[5:2] == 4'h4;
      analogLoopOn <= bist_q[5:2] == 4'h2;
      digitalLoopOn <= bist_q[5:2] == 4'h1;
      forwardRxToMac <= (bist_q[5:2] == 4'h8) &&
        bist_q[`PCB_BIT_FWDRX];
      // MII loop is taken to be the digital loop point.
      forwardTxToLine <= (bist_q[5:2] == 4'h1) &&
        bist_q[`PCB_BIT_FWDTX];
      if (speedSelect == `PCB_SPD_1G)
        codingLoopPoint <= {2'h0, codingLoopSelect[0]};
      else if (speedSelect == `PCB_SPD_100)
        codingLoopPoint <= {codingLoopSelect == 2'h3,
          codingLoopSelect == 2'h2, codingLoopSelect == 2'h1};
      else
        codingLoopPoint <= 3'h0;
    end
  end
endmodule
`default_nettype wire

// [bench/pcb_config_regs_sva.sv]
// Port-level assertions for the configuration and self-test register bank.
`timescale 1ns/1ps
`default_nettype none
module pcb_config_regs_sva (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  // Link and self-test
  input wire logic gigFailPulse,
  input wire logic fastFailPulse,
  input wire logic [1:0] speedSelect,
  input wire logic stByteValid,
  input wire logic [7:0] stByteData,
  input wire logic stFrameEnd,
  input wire logic prbsCheckEnable,
  input wire logic [3:0] loopSelectOneHot,
  input wire logic reverseLoopOn,
  input wire logic digitalLoopOn,
  input wire logic forwardRxToMac,
  input wire logic forwardTxToLine
);
  logic [15:0] byteCnt_q;
  logic rdTaken;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  assign rdTaken = hsel && hreadyout && htrans[1] && !hwrite;
  // Bytes of a frame come back to back, so a gap also restarts the tally.
  always @(posedge mclk)
    if (rst || !stByteValid || stFrameEnd)
      byteCnt_q <= 16'h0000;
    else
      byteCnt_q <= byteCnt_q + 16'h0001;
  AST_UNMAPPED:
  assert property (rdTaken && (haddr < 32'h50 || haddr > 32'h5f)
    |=> hrdata == 32'h0) else $error("unmapped read not zero");
  AST_PHY_CONFIG_TWO_FIXED:
  assert property (rdTaken && haddr == 32'h50 |=> hrdata[31:14] == 18'h0
    && !hrdata[12] && !hrdata[7] && hrdata[5:0] == 6'h07)
    else $error("config reserved bits wrong");
  AST_LOOP_ONEHOT:
  assert property (reverseLoopOn == (loopSelectOneHot == 4'h8)
    && digitalLoopOn == (loopSelectOneHot == 4'h1))
    else $error("loop decode wrong");
  AST_FWD_RX:
  assert property (forwardRxToMac |-> reverseLoopOn)
    else $error("rx forward outside reverse loop");
  AST_FWD_TX:
  assert property (forwardTxToLine |-> digitalLoopOn)
    else $error("tx forward outside digital loop");
  AST_NO_SKIP:
  assert property (speedSelect == 2'h0 |-> $past(speedSelect) != 2'h2)
    else $error("speed jumped from gigabit to ten");
  AST_TO_TEN:
  assert property (speedSelect == 2'h0 && $past(speedSelect) == 2'h1
    |-> $past(fastFailPulse) || $past(fastFailPulse, 2))
    else $error("ten fallback without fast failure");
  AST_TO_100:
  assert property (speedSelect == 2'h1 && $past(speedSelect) == 2'h2
    |-> $past(gigFailPulse) || $past(gigFailPulse, 2))
    else $error("downshift without gigabit failure");
  AST_CONST_DATA:
  assert property (stByteValid && !prbsCheckEnable |-> stByteData == 8'h55)
    else $error("constant payload wrong");
  AST_FRAME_LEN:
  assert property (stFrameEnd |-> stByteValid
    && (byteCnt_q == 16'd63 || byteCnt_q == 16'd1517))
    else $error("frame length wrong");
  COV_FRAME: cover property (stFrameEnd);
  COV_TEN: cover property (speedSelect == 2'h0);
  COV_REV: cover property (forwardRxToMac);
endmodule
bind pcb_config_regs pcb_config_regs_sva chk_u (.mclk, .rst, .hsel, .haddr,
  .htrans, .hwrite, .hrdata, .hreadyout, .gigFailPulse, .fastFailPulse,
  .speedSelect, .stByteValid, .stByteData, .stFrameEnd, .prbsCheckEnable,
  .loopSelectOneHot, .reverseLoopOn, .digitalLoopOn, .forwardRxToMac,
  .forwardTxToLine);
`default_nettype wire

// [bench/pcb_config_regs_bench.sv]
// Directed bench for the configuration, error tally and self-test registers.
`timescale 1ns/1ps
`default_nettype none
module pcb_config_regs_bench;
  logic mclk, rst, hsel, hwrite, hresp, hreadyout, linkUpPulse;
  logic [31:0] haddr, hwdata, hrdata, rdv, v;
  logic [1:0] htrans, speedSelect;
  logic gigFailPulse, fastFailPulse, pairsCdEnergy, rxErrorPulse;
  logic downshiftIrqEnable, otherIrqPending, downshiftEventPulse, irqPin;
  logic stByteValid, stFrameEnd, stWrapPulse, prbsCheckEnable;
  logic reverseLoopOn, externalLoopOn, analogLoopOn, digitalLoopOn;
  logic forwardRxToMac, forwardTxToLine;
  logic [7:0] stByteData;
  logic [3:0] loopSelectOneHot;
  logic [2:0] codingLoopPoint;
  int fails, comparisons, bytes, frames, b0, f0, events, wraps, w0;
  pcb_config_regs dut_u (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .gigFailPulse, .fastFailPulse, .linkUpPulse, .pairsCdEnergy,
    .rxErrorPulse, .downshiftIrqEnable, .otherIrqPending, .speedSelect,
    .downshiftEventPulse, .irqPin, .stByteValid, .stByteData, .stFrameEnd,
    .stWrapPulse, .prbsCheckEnable, .loopSelectOneHot, .reverseLoopOn,
    .externalLoopOn, .analogLoopOn, .digitalLoopOn, .forwardRxToMac,
    .forwardTxToLine, .codingLoopPoint);
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    bytes <= bytes + stByteValid;
    frames <= frames + stFrameEnd;
    events <= events + downshiftEventPulse;
    wraps <= wraps + stWrapPulse;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // The slave never stretches a phase, but both waits still follow hreadyout.
  task automatic bus(input logic w, input logic [31:0] a, d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask
  task automatic rd(input logic [31:0] a, exp);
    bus(1'b0, a, 32'h0);
    chk(rdv, exp);
  endtask
  task automatic pulse(input logic fast, input int n);
    repeat (n)
    begin
      gigFailPulse <= !fast;
      fastFailPulse <= fast;
      @(posedge mclk);
      gigFailPulse <= 1'b0;
      fastFailPulse <= 1'b0;
      repeat (3) @(posedge mclk);
    end
  endtask
  task automatic gen(input logic [31:0] val, input int n);
    b0 = bytes;
    f0 = frames;
    w0 = wraps;
    bus(1'b1, 32'h58, val);
    repeat (n) @(posedge mclk);
  endtask
  task automatic results;
    $display("comparisons %0d, fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #9000000;
    fails++;
    results;
  end
  initial
  begin
    {hsel, hwrite, gigFailPulse, fastFailPulse, linkUpPulse} = '0;
    {pairsCdEnergy, rxErrorPulse, downshiftIrqEnable, otherIrqPending} = '0;
    {htrans, haddr, hwdata} = '0;
    {fails, comparisons, bytes, frames, events, wraps} = '0;
    rst = 1'b1;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    chk(irqPin, 1'b1);
    rd(32'h50, 32'h2947);
    rd(32'h54, 32'h0);
    rd(32'h58, 32'h0);
    bus(1'b1, 32'h50, 32'hffff);
    rd(32'h50, 32'h2f47);
    bus(1'b1, 32'h60, 32'hffff);
    rd(32'h60, 32'h0);
    chk(hresp, 1'b0);
    rxErrorPulse <= 1'b1;
    repeat (3) @(posedge mclk);
    rxErrorPulse <= 1'b0;
    rd(32'h54, 32'h3);
    bus(1'b1, 32'h54, 32'h1234);
    rd(32'h54, 32'h0);
    rxErrorPulse <= 1'b1;
    repeat (65540) @(posedge mclk);
    rxErrorPulse <= 1'b0;
    rd(32'h54, 32'hffff);
    downshiftIrqEnable <= 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      bus(1'b1, 32'h50, 32'h2000 | (c << 10));
      bus(1'b1, 32'h50, 32'h2240 | (c << 10));
      pulse(1'b0, (1 << c) - 1);
      chk(speedSelect, 2'h2);
      pulse(1'b0, 1);
      chk(speedSelect, 2'h1);
      chk(irqPin, 1'b0);
      rd(32'h5c, 32'h20);
      rd(32'h5c, 32'h0);
      repeat (2) @(posedge mclk);
      chk(irqPin, 1'b1);
    end
    pulse(1'b1, 1);
    chk(speedSelect, 2'h0);
    chk(events, 5);
    bus(1'b1, 32'h50, 32'h2000);
    bus(1'b1, 32'h50, 32'h2200);
    pulse(1'b0, 1);
    pulse(1'b1, 1);
    chk(speedSelect, 2'h1);
    bus(1'b1, 32'h50, 32'h2000);
    bus(1'b1, 32'h50, 32'h2f00);
    pairsCdEnergy <= 1'b1;
    pulse(1'b0, 1);
    chk(speedSelect, 2'h2);
    pairsCdEnergy <= 1'b0;
    pulse(1'b0, 1);
    chk(speedSelect, 2'h1);
    bus(1'b1, 32'h50, 32'h2000);
    bus(1'b1, 32'h50, 32'h2c00);
    pulse(1'b0, 8);
    chk(speedSelect, 2'h2);
    bus(1'b1, 32'h50, 32'h0000);
    bus(1'b0, 32'h5c, 32'h0);
    otherIrqPending <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(irqPin, 1'b1);
    otherIrqPending <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(irqPin, 1'b0);
    // Continuous mode stays set in every self-test write.
    gen(32'hb000, 2);
    rd(32'h5c, 32'h200);
    repeat (300) @(posedge mclk);
    chk(bytes - b0, 64);
    chk(frames - f0, 1);
    chk(wraps - w0, 1);
    chk(prbsCheckEnable, 1'b0);
    rd(32'h5c, 32'h0);
    bus(1'b1, 32'h58, 32'h8000);
    gen(32'h9000, 2000);
    chk(bytes - b0, 1518);
    bus(1'b1, 32'h58, 32'h8000);
    gen(32'hf000, 400);
    chk(frames - f0 > 1, 1'b1);
    rd(32'h5c, 32'h200);
    bus(1'b1, 32'h58, 32'hc000);
    repeat (2) @(posedge mclk);
    chk(prbsCheckEnable, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      v = 32'h8000 | (32'h4 << i) | (i == 3 ? 32'h80 : 0) |
        (i == 0 ? 32'h40 : 0);
      bus(1'b1, 32'h58, v);
      repeat (2) @(posedge mclk);
      chk(loopSelectOneHot, 4'h1 << i);
      chk({reverseLoopOn, externalLoopOn, analogLoopOn, digitalLoopOn},
        4'h1 << i);
      chk({forwardRxToMac, forwardTxToLine}, {i == 3, i == 0});
      rd(32'h58, v);
    end
    bus(1'b1, 32'h58, 32'h8f03);
    rd(32'h58, 32'h8003);
    chk(codingLoopPoint, 3'h1);
    bus(1'b1, 32'h58, 32'h8000);
    bus(1'b1, 32'h58, 32'h8002);
    bus(1'b1, 32'h50, 32'h2200);
    pulse(1'b0, 1);
    chk(speedSelect, 2'h1);
    chk(codingLoopPoint, 3'h2);
    results;
  end
endmodule
`default_nettype wire
